// file: rtl/brk_b_pkg.sv
package brk_b_pkg;

  // Register offsets on the APB word grid.
  localparam logic [7:0] OFF_REF_ADDR  = 8'h00;
  localparam logic [7:0] OFF_ADDR_MASK = 8'h04;
  localparam logic [7:0] OFF_DATA_CMP  = 8'h08;
  localparam logic [7:0] OFF_DATA_MASK = 8'h0c;
  localparam logic [7:0] OFF_BUS_CFG   = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [7:0] OFF_INT_MASK  = 8'h18;

  // Reset values.
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]  RST_FIELD2 = 2'h0;
  localparam logic        RST_BIT    = 1'h0;

  // Field positions inside the bus cycle configuration word, and the bit used in the status and interrupt mask words.
  localparam int unsigned SEL_LSB  = 6;
  localparam int unsigned SIZE_LSB = 0;
  localparam int unsigned STAT_BIT = 0;

  // Bus select codes.
  localparam logic [1:0] SEL_OFF     = 2'h0;
  localparam logic [1:0] SEL_LOCAL_A = 2'h1;
  localparam logic [1:0] SEL_INSTR   = 2'h2;
  localparam logic [1:0] SEL_LOCAL_B = 2'h3;

  // Operand size codes, shared with the size lines of both buses.
  localparam logic [1:0] SIZE_ANY  = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;

  // Upper half is ignored on byte compares; the byte is duplicated in 15:8 and 7:0.
  localparam logic [31:0] BYTE_LANE_MASK = 32'hffff_0000;

  // Which bus the channel watches.
  typedef enum logic [1:0] {
    BUS_NONE,
    BUS_LOCAL,
    BUS_INSTR
  } bus_choice_t;

endpackage : brk_b_pkg

// file: rtl/masked_eq_compare.sv
module masked_eq_compare (
  // Operands.
  input  wire logic [31:0] value,
  input  wire logic [31:0] ref_value,
  input  wire logic [31:0] mask,
  // Result.
  output logic             equal
);

  logic [31:0] bit_ok;

  // A set mask bit drops that bit from the comparison.
  for (genvar i = 0; i < 32; i++) begin : g_bit
    assign bit_ok[i] = mask[i] | (value[i] == ref_value[i]);
  end

  // All kept bits must agree.
  assign equal = &bit_ok;

endmodule : masked_eq_compare

// file: rtl/break_channel_b_addr_data_match.sv
// Implementation choices: the APB interface to the registers and the register addresses.
module break_channel_b_addr_data_match (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction bus snoop.
  input  wire logic        instr_bus_valid,
  input  wire logic [31:0] instr_bus_address_lines,
  input  wire logic [31:0] instr_bus_data_lines,
  input  wire logic [1:0]  instr_bus_size,
  // Local bus snoop.
  input  wire logic        local_bus_valid,
  input  wire logic [31:0] local_bus_address_lines,
  input  wire logic [31:0] local_bus_data_lines,
  input  wire logic [1:0]  local_bus_size,
  // Results.
  output logic             chan_b_match,
  output logic             irq
);

  typedef struct packed {
    logic [31:0] chan_b_reference_address;
    logic [31:0] chan_b_address_mask;
    logic [31:0] chan_b_data_compare;
    logic [31:0] chan_b_data_mask;
    logic [1:0]  chan_b_bus_select;
    logic [1:0]  chan_b_operand_size;
    logic        status;
    logic        int_mask;
    logic        match;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t                state;
  state_t                next_state;
  brk_b_pkg::bus_choice_t choice;
  logic                  sel_valid;
  logic [31:0]           sel_addr;
  logic [31:0]           sel_data;
  logic [1:0]            sel_size;
  logic [31:0]           eff_data_mask;
  logic                  addr_ok;
  logic                  data_ok;
  logic                  size_ok;
  logic                  data_used;
  logic                  hit;
  logic                  setup;
  logic                  wr_take;
  logic                  addr_known;
  logic [31:0]           read_word;
  logic                  stat_clear;

  // Decode the bus select field; both 01 and 11 mean the local bus.
  always_comb begin
    case (state.chan_b_bus_select)
      brk_b_pkg::SEL_LOCAL_A,
      brk_b_pkg::SEL_LOCAL_B: choice = brk_b_pkg::BUS_LOCAL;
      brk_b_pkg::SEL_INSTR:   choice = brk_b_pkg::BUS_INSTR;
      default:                choice = brk_b_pkg::BUS_NONE;
    endcase
  end

  // Route the chosen bus to the comparators; no bus means no cycle to compare.
  always_comb begin
    case (choice)
      brk_b_pkg::BUS_INSTR: begin
        sel_valid = instr_bus_valid;
        sel_addr  = instr_bus_address_lines;
        sel_data  = instr_bus_data_lines;
        sel_size  = instr_bus_size;
      end
      brk_b_pkg::BUS_LOCAL: begin
        sel_valid = local_bus_valid;
        sel_addr  = local_bus_address_lines;
        sel_data  = local_bus_data_lines;
        sel_size  = local_bus_size;
      end
      default: begin
        sel_valid = 1'b0;
        sel_addr  = brk_b_pkg::RST_WORD;
        sel_data  = brk_b_pkg::RST_WORD;
        sel_size  = brk_b_pkg::SIZE_ANY;
      end
    endcase
  end

  // Byte compares look at the low half only, since software duplicates the byte there.
  assign eff_data_mask = state.chan_b_data_mask
                       | ((state.chan_b_operand_size == brk_b_pkg::SIZE_BYTE)
                          ? brk_b_pkg::BYTE_LANE_MASK : brk_b_pkg::RST_WORD);

  masked_eq_compare u_addr_cmp (
    .value     (sel_addr),
    .ref_value (state.chan_b_reference_address),
    .mask      (state.chan_b_address_mask),
    .equal     (addr_ok)
  );

  masked_eq_compare u_data_cmp (
    .value     (sel_data),
    .ref_value (state.chan_b_data_compare),
    .mask      (eff_data_mask),
    .equal     (data_ok)
  );

  // Data only counts with a size set, so an unsized setup can never see stray data.
  assign data_used = (state.chan_b_operand_size != brk_b_pkg::SIZE_ANY);
  assign size_ok   = !data_used || (sel_size == state.chan_b_operand_size);
  assign hit       = sel_valid && addr_ok && size_ok && (!data_used || data_ok);

  // APB decode; reads are prepared in the setup cycle.
  assign setup      = psel && !penable;
  assign wr_take    = psel && penable && state.pready && pwrite;
  assign stat_clear = wr_take && (paddr == brk_b_pkg::OFF_STATUS)
                      && pwdata[brk_b_pkg::STAT_BIT];

  // Register read multiplexer; unused bits read as zero.
  always_comb begin
    addr_known = 1'b1;
    read_word  = brk_b_pkg::RST_WORD;
    case (paddr)
      brk_b_pkg::OFF_REF_ADDR:  read_word = state.chan_b_reference_address;
      brk_b_pkg::OFF_ADDR_MASK: read_word = state.chan_b_address_mask;
      brk_b_pkg::OFF_DATA_CMP:  read_word = state.chan_b_data_compare;
      brk_b_pkg::OFF_DATA_MASK: read_word = state.chan_b_data_mask;
      brk_b_pkg::OFF_BUS_CFG: begin
        read_word[brk_b_pkg::SEL_LSB +: 2]  = state.chan_b_bus_select;
        read_word[brk_b_pkg::SIZE_LSB +: 2] = state.chan_b_operand_size;
      end
      brk_b_pkg::OFF_STATUS:   read_word[brk_b_pkg::STAT_BIT] = state.status;
      brk_b_pkg::OFF_INT_MASK: read_word[brk_b_pkg::STAT_BIT] = state.int_mask;
      default:                 addr_known = 1'b0;
    endcase
  end

  // Next state: bus answer, register writes, sticky status and interrupt.
  always_comb begin
    next_state         = state;
    next_state.pready  = setup;
    next_state.pslverr = setup && !addr_known;
    if (setup) begin
      next_state.prdata = read_word;
    end
    if (wr_take) begin
      case (paddr)
        brk_b_pkg::OFF_REF_ADDR:  next_state.chan_b_reference_address = pwdata;
        brk_b_pkg::OFF_ADDR_MASK: next_state.chan_b_address_mask = pwdata;
        brk_b_pkg::OFF_DATA_CMP:  next_state.chan_b_data_compare = pwdata;
        brk_b_pkg::OFF_DATA_MASK: next_state.chan_b_data_mask = pwdata;
        brk_b_pkg::OFF_BUS_CFG: begin
          next_state.chan_b_bus_select   = pwdata[brk_b_pkg::SEL_LSB +: 2];
          next_state.chan_b_operand_size = pwdata[brk_b_pkg::SIZE_LSB +: 2];
        end
        brk_b_pkg::OFF_INT_MASK: next_state.int_mask = pwdata[brk_b_pkg::STAT_BIT];
        default: next_state.int_mask = state.int_mask;
      endcase
    end
    // A match in the clearing cycle wins, so no event is lost.
    next_state.status = (state.status && !stat_clear) || hit;
    next_state.match  = hit;
    next_state.irq    = state.status && state.int_mask;
  end

  // All state in one register; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.chan_b_reference_address <= brk_b_pkg::RST_WORD;
      state.chan_b_address_mask      <= brk_b_pkg::RST_WORD;
      state.chan_b_data_compare      <= brk_b_pkg::RST_WORD;
      state.chan_b_data_mask         <= brk_b_pkg::RST_WORD;
      state.chan_b_bus_select        <= brk_b_pkg::RST_FIELD2;
      state.chan_b_operand_size      <= brk_b_pkg::RST_FIELD2;
      state.status                   <= brk_b_pkg::RST_BIT;
      state.int_mask                 <= brk_b_pkg::RST_BIT;
      state.match                    <= brk_b_pkg::RST_BIT;
      state.irq                      <= brk_b_pkg::RST_BIT;
      state.pready                   <= brk_b_pkg::RST_BIT;
      state.pslverr                  <= brk_b_pkg::RST_BIT;
      state.prdata                   <= brk_b_pkg::RST_WORD;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register.
  assign prdata       = state.prdata;
  assign pready       = state.pready;
  assign pslverr      = state.pslverr;
  assign chan_b_match = state.match;
  assign irq          = state.irq;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write_to(logic [7:0] off);
    psel && penable && pready && pwrite && (paddr == off);
  endsequence

  sequence s_instr_sel;
    (state.chan_b_bus_select == brk_b_pkg::SEL_INSTR) && instr_bus_valid;
  endsequence

  sequence s_local_sel;
    ((state.chan_b_bus_select == brk_b_pkg::SEL_LOCAL_A)
     || (state.chan_b_bus_select == brk_b_pkg::SEL_LOCAL_B)) && local_bus_valid;
  endsequence

  a_addr_mask_write:
    assert property (s_write_to(brk_b_pkg::OFF_ADDR_MASK)
                     |=> state.chan_b_address_mask == $past(pwdata))
    else $error("Address mask did not take the written word.");

  a_data_cmp_write:
    assert property (s_write_to(brk_b_pkg::OFF_DATA_CMP)
                     ##1 (psel && !penable && !pwrite && paddr == brk_b_pkg::OFF_DATA_CMP)
                     |=> prdata == $past(pwdata, 2))
    else $error("Data compare value did not read back.");

  a_data_mask_write:
    assert property (s_write_to(brk_b_pkg::OFF_DATA_MASK)
                     |=> state.chan_b_data_mask == $past(pwdata))
    else $error("Data mask did not take the written word.");

  a_instr_full_hit:
    assert property (s_instr_sel
                     and ##0 ((instr_bus_address_lines ^ state.chan_b_reference_address)
                              & ~state.chan_b_address_mask) == 32'h0000_0000
                     and ##0 state.chan_b_operand_size == brk_b_pkg::SIZE_ANY
                     |=> chan_b_match)
    else $error("Instruction bus hit was not reported.");

  a_local_data_hit:
    assert property (s_local_sel
                     and ##0 state.chan_b_operand_size == local_bus_size
                     and ##0 local_bus_size != brk_b_pkg::SIZE_ANY
                     and ##0 ((local_bus_address_lines ^ state.chan_b_reference_address)
                              & ~state.chan_b_address_mask) == 32'h0000_0000
                     and ##0 ((local_bus_data_lines ^ state.chan_b_data_compare)
                              & ~eff_data_mask) == 32'h0000_0000
                     |=> chan_b_match)
    else $error("Local bus data hit was not reported.");

  a_addr_bit_miss:
    assert property (((sel_addr ^ state.chan_b_reference_address)
                      & ~state.chan_b_address_mask) != 32'h0000_0000
                     |=> !chan_b_match)
    else $error("Match reported on an unmasked address difference.");

  a_data_bit_miss:
    assert property (data_used
                     && ((sel_data ^ state.chan_b_data_compare) & ~eff_data_mask)
                        != 32'h0000_0000
                     |=> !chan_b_match)
    else $error("Match reported on an unmasked data difference.");

  a_select_off:
    assert property (state.chan_b_bus_select == brk_b_pkg::SEL_OFF |=> !chan_b_match)
    else $error("Match reported with comparison disabled.");

  a_byte_size_only:
    assert property (state.chan_b_operand_size == brk_b_pkg::SIZE_BYTE
                     && sel_size != brk_b_pkg::SIZE_BYTE |=> !chan_b_match)
    else $error("Byte condition matched a non-byte access.");

  a_cycle_needed:
    assert property (chan_b_match |-> $past(sel_valid))
    else $error("Match reported without a selected bus cycle.");

  a_irq_follows:
    assert property (chan_b_match && state.int_mask && !wr_take
                     |=> irq [*2])
    else $error("Unmasked match did not raise the interrupt.");

endmodule : break_channel_b_addr_data_match

// file: tb/core_bus_model.sv
module core_bus_model (
  // Clock.
  input  wire logic   pclk,
  // Instruction bus.
  output logic        instr_bus_valid,
  output logic [31:0] instr_bus_address_lines,
  output logic [31:0] instr_bus_data_lines,
  output logic [1:0]  instr_bus_size,
  // Local bus.
  output logic        local_bus_valid,
  output logic [31:0] local_bus_address_lines,
  output logic [31:0] local_bus_data_lines,
  output logic [1:0]  local_bus_size
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        own_instr = 1'b0;
  logic        own_local = 1'b0;
  logic [31:0] a_q = 32'h0000_0000;
  logic [31:0] d_q = 32'h0000_0000;
  logic [1:0]  s_q = 2'h0;

  // A bus that holds no cycle shows the inverse of the last value, so stale lines never match.
  assign instr_bus_valid         = own_instr;
  assign instr_bus_address_lines = own_instr ? a_q : ~a_q;
  assign instr_bus_data_lines    = own_instr ? d_q : ~d_q;
  assign instr_bus_size          = own_instr ? s_q : ~s_q;
  assign local_bus_valid         = own_local;
  assign local_bus_address_lines = own_local ? a_q : ~a_q;
  assign local_bus_data_lines    = own_local ? d_q : ~d_q;
  assign local_bus_size          = own_local ? s_q : ~s_q;

  // One bus cycle lasts exactly one clock on the chosen bus.
  task automatic cycle(input logic instr, input logic [31:0] a, input logic [31:0] d,
                       input logic [1:0] sz);
    @(posedge pclk);
    own_instr <= instr;
    own_local <= !instr;
    a_q       <= a;
    d_q       <= d;
    s_q       <= sz;
    @(posedge pclk);
    own_instr <= 1'b0;
    own_local <= 1'b0;
  endtask : cycle
endmodule : core_bus_model

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, chan_b_match, irq;
  logic        instr_bus_valid, local_bus_valid;
  logic [31:0] instr_bus_address_lines, instr_bus_data_lines;
  logic [31:0] local_bus_address_lines, local_bus_data_lines;
  logic [1:0]  instr_bus_size, local_bus_size;
  logic [31:0] rd_q[$];
  logic        exp_q[$];
  logic        was_valid = 1'b0;
  bit          kept = 1'b0; // Last transfer left psel high for a setup that follows at once.
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] ra, rdat, rnd;
  int          k;

  always #5 pclk = ~pclk;

  break_channel_b_addr_data_match u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_bus_valid(instr_bus_valid),
    .instr_bus_address_lines(instr_bus_address_lines),
    .instr_bus_data_lines(instr_bus_data_lines), .instr_bus_size(instr_bus_size),
    .local_bus_valid(local_bus_valid), .local_bus_address_lines(local_bus_address_lines),
    .local_bus_data_lines(local_bus_data_lines), .local_bus_size(local_bus_size),
    .chan_b_match(chan_b_match), .irq(irq));

  core_bus_model u_bus (.pclk(pclk), .instr_bus_valid(instr_bus_valid),
    .instr_bus_address_lines(instr_bus_address_lines),
    .instr_bus_data_lines(instr_bus_data_lines), .instr_bus_size(instr_bus_size),
    .local_bus_valid(local_bus_valid), .local_bus_address_lines(local_bus_address_lines),
    .local_bus_data_lines(local_bus_data_lines), .local_bus_size(local_bus_size));

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // APB transfer; the request is held until pready is seen high at a rising edge.
  // Penable is always low between transfers, so a chained setup keeps psel high and starts at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
                     input bit keep = 1'b0);
    if (!kept) @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    check(32'(pslverr), 32'(err), "error flag");
    penable <= 1'b0;
    if (!keep) psel <= 1'b0;
    kept = keep;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000, err);
  endtask : rd

  task automatic snoop(input logic instr, input logic [31:0] a, input logic [31:0] d,
                       input logic [1:0] sz, input logic exp);
    exp_q.push_back(exp);
    u_bus.cycle(instr, a, d, sz);
  endtask : snoop

  // Scoreboard: read data at each completed read, match flag one clock after each bus cycle.
  always @(posedge pclk) begin
    was_valid <= instr_bus_valid | local_bus_valid;
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
      check(prdata, rd_q.pop_front(), "read data");
    end
    if (was_valid && exp_q.size() > 0) begin
      check(32'(chan_b_match), 32'(exp_q.pop_front()), "match flag");
    end
  end

  // The whole run needs well under a thousand clocks; this only cuts a hang short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    rnd = $urandom(21);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      rd(8'(4 * i), 32'h0000_0000);
      rnd = $urandom;
      apb(1'b1, 8'(4 * i), rnd, 1'b0);
      rd(8'(4 * i), rnd);
    end
    rd(8'h1c, 32'h0000_0000, 1'b1);
    ra = $urandom;
    rnd = $urandom;
    rdat = {rnd[31:16], rnd[7:0], rnd[7:0]};
    apb(1'b1, brk_b_pkg::OFF_REF_ADDR, ra, 1'b0);
    apb(1'b1, brk_b_pkg::OFF_ADDR_MASK, 32'h0000_0000, 1'b0);
    apb(1'b1, brk_b_pkg::OFF_DATA_CMP, rdat, 1'b0, 1'b1);
    rd(brk_b_pkg::OFF_DATA_CMP, rdat);
    apb(1'b1, brk_b_pkg::OFF_DATA_MASK, 32'h0000_0000, 1'b0);
    // Every select code against both buses, address only, with wrong data on the lines.
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, brk_b_pkg::OFF_BUS_CFG, 32'(s) << 6, 1'b0);
      for (int b = 0; b < 2; b++) begin
        snoop(b[0], ra, ~rdat, 2'h2, s != 0 && (b == 1) == (s == 2));
        snoop(b[0], ~ra, rdat, 2'h2, 1'b0);
      end
    end
    k = $urandom_range(31);
    apb(1'b1, brk_b_pkg::OFF_BUS_CFG, 32'h0000_0080, 1'b0);
    apb(1'b1, brk_b_pkg::OFF_ADDR_MASK, 32'h1 << k, 1'b0);
    snoop(1'b1, ra ^ (32'h1 << k), rdat, 2'h1, 1'b1);
    snoop(1'b1, ra ^ (32'h1 << ((k + 1) % 32)), rdat, 2'h1, 1'b0);
    // Byte size on the local bus: upper half ignored, size lines must show a byte.
    apb(1'b1, brk_b_pkg::OFF_BUS_CFG, 32'h0000_0041, 1'b0);
    snoop(1'b0, ra, {~rdat[31:16], rdat[15:0]}, brk_b_pkg::SIZE_BYTE, 1'b1);
    snoop(1'b0, ra, rdat, 2'h2, 1'b0);
    snoop(1'b0, ra, rdat ^ 32'h0000_0101, brk_b_pkg::SIZE_BYTE, 1'b0);
    apb(1'b1, brk_b_pkg::OFF_DATA_MASK, 32'h0000_0101, 1'b0);
    snoop(1'b0, ra, rdat ^ 32'h0000_0101, brk_b_pkg::SIZE_BYTE, 1'b1);
    // Instruction bus data compare with a bit outside the data mask.
    apb(1'b1, brk_b_pkg::OFF_BUS_CFG, 32'h0000_0081, 1'b0);
    snoop(1'b1, ra, rdat, brk_b_pkg::SIZE_BYTE, 1'b1);
    snoop(1'b1, ra, rdat ^ 32'h0000_0002, brk_b_pkg::SIZE_BYTE, 1'b0);
    // Sticky status, masked then unmasked interrupt, write one to clear.
    rd(brk_b_pkg::OFF_STATUS, 32'h0000_0001);
    check(32'(irq), 32'h0, "masked irq");
    apb(1'b1, brk_b_pkg::OFF_INT_MASK, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1, "irq raised");
    apb(1'b1, brk_b_pkg::OFF_STATUS, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0, "irq cleared");
    rd(brk_b_pkg::OFF_STATUS, 32'h0000_0000);
    snoop(1'b1, ra, rdat, brk_b_pkg::SIZE_BYTE, 1'b1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1, "irq on new match");
    repeat (3) @(posedge pclk);
    results();
  end
endmodule : tb
